// ==== common/relay_pkg.sv ====
// Operation
// - Each sample/cal, zero/span, shutoff valve switched individually
// - IR source enable held on normally
// - Host toggles indicator; device drives last written value
// - Sample/cal LED lit when routing cal gas
// - Zero/span LED lit when span selected
// - Shutoff LED lit while valve open
// - Watchdog observes bus activity through indicator
// - Indicator static 30 s forces valves, source, heaters off
// - Shutdown leaves wheel motor at its last commanded value
// - Addressed bus writes decoded into parallel output bits
// - Power-up hold at fixed values until host control
// - Interpret received instructions, actuate switches and relays
// - Wheel heater is a plain on/off output
package relay_pkg;

  // Serial bus identity of this board, value arbitrary
  localparam logic [6:0]  I2C_ADDR       = 7'h20;

  // Register offsets on APB
  localparam logic [7:0]  REG_STATUS     = 8'h00;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h04;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
  localparam logic [7:0]  REG_CONFIG     = 8'h0C;

  // Interrupt status bit positions
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_TRIP       = 0;
  localparam int          IRQ_TAKEOVER   = 1;
  localparam int          IRQ_CMD        = 2;

  // Status register field positions
  localparam int          ST_DRIVE_LSB   = 0;
  localparam int          ST_LED_LSB     = 8;
  localparam int          ST_HOST        = 16;
  localparam int          ST_TRIPPED     = 17;

  // Config register field positions and reset value
  localparam int          CFG_WD_EN      = 0;
  localparam logic [31:0] CONFIG_RST     = 32'h0000_0001;

  // Data byte order inside one bus write
  localparam logic [1:0]  IDX_DRIVE      = 2'h0;
  localparam logic [1:0]  IDX_INDICATOR  = 2'h1;
  localparam int          IND_WATCHDOG   = 0;
  localparam int          IND_SPARE      = 1;

  // Watchdog timing
  localparam longint unsigned CLK_HZ         = 250_000_000;
  localparam longint unsigned WDOG_TIMEOUT_S = 30;
  localparam longint unsigned WDOG_CYCLES    = WDOG_TIMEOUT_S * CLK_HZ;
  localparam int              WDOG_W         = 33;
  localparam int              HOST_TOGGLE_S  = 3;

  typedef struct packed {
    logic wheel_motor;
    logic ir_source;
    logic bench_heater;
    logic wheel_heater;
    logic shutoff_valve;
    logic zero_span_valve;
    logic sample_cal_valve;
  } drive_t;

  typedef struct packed {
    logic ir_source_led;
    logic shutoff_valve_led;
    logic zero_span_valve_led;
    logic sample_cal_valve_led;
    logic spare_led;
    logic bench_heater_led;
    logic wheel_heater_led;
    logic watchdog_indicator_led;
  } led_t;

  // Values held from reset until the host takes control, and the watchdog shutdown value
  localparam drive_t      DRIVE_POWERUP  = 7'h60;
  localparam drive_t      DRIVE_SHUTDOWN = 7'h40;
  localparam logic [7:0]  IND_POWERUP    = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [1:0] idx;
    logic [7:0] data;
  } i2c_wr_t;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADRS  = 3'b001,
    I2C_ACK_A = 3'b010,
    I2C_DATA  = 3'b011,
    I2C_ACK_D = 3'b100
  } i2c_state_t;

endpackage : relay_pkg

// ==== design/i2c_write_slave.sv ====
`timescale 1ns/1ns
module i2c_write_slave #(
  parameter logic [6:0] ADDR = relay_pkg::I2C_ADDR
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Serial pins
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Received data
  output relay_pkg::i2c_wr_t     wr
);

  logic                  scl_m;
  logic                  scl_s;
  logic                  scl_p;
  logic                  sda_m;
  logic                  sda_s;
  logic                  sda_p;
  logic                  start;
  logic                  stop;
  logic                  rise;
  logic                  fall;
  logic [2:0]            bitcnt;
  logic                  full;
  logic [7:0]            shreg;
  logic [1:0]            idx;
  relay_pkg::i2c_state_t state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop  = scl_s & scl_p & ~sda_p & sda_s;
  assign rise  = scl_s & ~scl_p;
  assign fall  = ~scl_s & scl_p;

  // Only writes to our own address are acknowledged; reads are left unanswered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= relay_pkg::I2C_IDLE;
      bitcnt <= 3'h0;
      full   <= 1'b0;
      shreg  <= 8'h00;
      idx    <= 2'h0;
      sda_oe <= 1'b0;
    end else if (start) begin
      state  <= relay_pkg::I2C_ADRS;
      bitcnt <= 3'h0;
      full   <= 1'b0;
      idx    <= 2'h0;
      sda_oe <= 1'b0;
    end else if (stop) begin
      state  <= relay_pkg::I2C_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        relay_pkg::I2C_IDLE: begin
          sda_oe <= 1'b0;
        end
        relay_pkg::I2C_ADRS, relay_pkg::I2C_DATA: begin
          if (rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 3'h1;
            full   <= (bitcnt == 3'h7);
          end else if (fall && full) begin
            full <= 1'b0;
            if (state == relay_pkg::I2C_DATA) begin
              sda_oe <= 1'b1;
              state  <= relay_pkg::I2C_ACK_D;
            end else if (shreg[7:1] == ADDR && !shreg[0]) begin
              sda_oe <= 1'b1;
              state  <= relay_pkg::I2C_ACK_A;
            end else begin
              state <= relay_pkg::I2C_IDLE;
            end
          end
        end
        relay_pkg::I2C_ACK_A, relay_pkg::I2C_ACK_D: begin
          if (fall) begin
            sda_oe <= 1'b0;
            bitcnt <= 3'h0;
            state  <= relay_pkg::I2C_DATA;
            if (state == relay_pkg::I2C_ACK_D && idx != 2'h3) begin
              idx <= idx + 2'h1;
            end
          end
        end
        default: begin
          state  <= relay_pkg::I2C_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // One-cycle strobe when a data byte has been received, as its acknowledge starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr <= '0;
    end else begin
      wr.valid <= (state == relay_pkg::I2C_DATA) && fall && full && !start && !stop;
      wr.idx   <= idx;
      wr.data  <= shreg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

endmodule : i2c_write_slave

// ==== design/relay_board_io_watchdog.sv ====
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
module relay_board_io_watchdog #(
  parameter logic [6:0]      I2C_ADDR    = relay_pkg::I2C_ADDR,
  parameter longint unsigned WDOG_CYCLES = relay_pkg::WDOG_CYCLES
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq,
  // Serial bus from the host
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Switches, relays and indicators
  output relay_pkg::drive_t      drive,
  output relay_pkg::led_t        leds
);

  localparam logic [relay_pkg::WDOG_W-1:0] WDOG_LAST =
    relay_pkg::WDOG_W'(WDOG_CYCLES - 64'd1);

  relay_pkg::i2c_wr_t            wr;
  relay_pkg::drive_t             cmd_drive;
  logic [7:0]                    cmd_ind;
  logic                          host_ctrl;
  logic                          ind_prev;
  logic [relay_pkg::WDOG_W-1:0]  wd_cnt;
  logic                          tripped;
  logic                          wd_armed;
  logic                          ind_toggle;
  logic [31:0]                   config_reg;
  logic [relay_pkg::IRQ_W-1:0]   irq_stat;
  logic [relay_pkg::IRQ_W-1:0]   irq_mask;
  logic [relay_pkg::IRQ_W-1:0]   events;
  logic                          take_now;
  logic                          trip_now;
  relay_pkg::drive_t             next_drive;
  relay_pkg::led_t               next_leds;
  logic                          apb_access;
  logic                          apb_write;
  logic                          addr_ok;
  logic [31:0]                   rd_mux;
  logic [31:0]                   status_word;

  i2c_write_slave #(
    .ADDR    (I2C_ADDR)
  ) u_link (
    .pclk    (pclk),
    .presetn (presetn),
    .scl     (scl),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr      (wr)
  );

  // Command latches: drive byte and indicator byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_drive <= relay_pkg::DRIVE_POWERUP;
    end else if (wr.valid && wr.idx == relay_pkg::IDX_DRIVE) begin
      cmd_drive <= relay_pkg::drive_t'(wr.data[6:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ind <= relay_pkg::IND_POWERUP;
    end else if (wr.valid && wr.idx == relay_pkg::IDX_INDICATOR) begin
      cmd_ind <= wr.data;
    end
  end

  // First accepted byte hands control to the host
  assign take_now = wr.valid && !host_ctrl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ctrl <= 1'b0;
    end else if (wr.valid) begin
      host_ctrl <= 1'b1;
    end
  end

  // Watchdog on indicator toggles
  assign wd_armed   = host_ctrl && config_reg[relay_pkg::CFG_WD_EN];
  assign ind_toggle = cmd_ind[relay_pkg::IND_WATCHDOG] != ind_prev;
  assign trip_now   = wd_armed && !tripped && !ind_toggle && wd_cnt == WDOG_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_prev <= 1'b0;
    end else begin
      ind_prev <= cmd_ind[relay_pkg::IND_WATCHDOG];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt <= '0;
    end else if (!wd_armed || ind_toggle) begin
      wd_cnt <= '0;
    end else if (wd_cnt != WDOG_LAST) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // Shutdown holds until the indicator moves again or the watchdog is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tripped <= 1'b0;
    end else if (!wd_armed || ind_toggle) begin
      tripped <= 1'b0;
    end else if (trip_now) begin
      tripped <= 1'b1;
    end
  end

  // Output selection
  always_comb begin
    if (!host_ctrl) begin
      next_drive = relay_pkg::DRIVE_POWERUP;
    end else if (tripped) begin
      next_drive             = relay_pkg::DRIVE_SHUTDOWN;
      next_drive.wheel_motor = cmd_drive.wheel_motor;
    end else begin
      next_drive = cmd_drive;
    end
  end

  always_comb begin
    next_leds.watchdog_indicator_led = cmd_ind[relay_pkg::IND_WATCHDOG];
    next_leds.spare_led              = cmd_ind[relay_pkg::IND_SPARE];
    next_leds.wheel_heater_led       = next_drive.wheel_heater;
    next_leds.bench_heater_led       = next_drive.bench_heater;
    next_leds.sample_cal_valve_led   = next_drive.sample_cal_valve;
    next_leds.zero_span_valve_led    = next_drive.zero_span_valve;
    next_leds.shutoff_valve_led      = next_drive.shutoff_valve;
    next_leds.ir_source_led          = next_drive.ir_source;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= relay_pkg::DRIVE_POWERUP;
    end else begin
      drive <= next_drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds <= '0;
      leds.ir_source_led <= relay_pkg::DRIVE_POWERUP.ir_source;
    end else begin
      leds <= next_leds;
    end
  end

  // APB decode
  assign apb_access = psel && penable && !pready;
  assign apb_write  = psel && penable && pready && pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    unique case (paddr)
      relay_pkg::REG_STATUS:   rd_mux = status_word;
      relay_pkg::REG_IRQ_STAT: rd_mux = {{(32-relay_pkg::IRQ_W){1'b0}}, irq_stat};
      relay_pkg::REG_IRQ_MASK: rd_mux = {{(32-relay_pkg::IRQ_W){1'b0}}, irq_mask};
      relay_pkg::REG_CONFIG:   rd_mux = config_reg;
      default:                 addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[relay_pkg::ST_DRIVE_LSB +: 7] = drive;
    status_word[relay_pkg::ST_LED_LSB +: 8]   = leds;
    status_word[relay_pkg::ST_HOST]           = host_ctrl;
    status_word[relay_pkg::ST_TRIPPED]        = tripped;
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !addr_ok;
      if (apb_access && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= relay_pkg::CONFIG_RST;
    end else if (apb_write && paddr == relay_pkg::REG_CONFIG) begin
      config_reg <= {31'h0000_0000, pwdata[relay_pkg::CFG_WD_EN]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (apb_write && paddr == relay_pkg::REG_IRQ_MASK) begin
      irq_mask <= pwdata[relay_pkg::IRQ_W-1:0];
    end
  end

  // Sticky events, set wins over a write-one clear
  always_comb begin
    events                         = '0;
    events[relay_pkg::IRQ_TRIP]    = trip_now;
    events[relay_pkg::IRQ_TAKEOVER] = take_now;
    events[relay_pkg::IRQ_CMD]     = wr.valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (apb_write && paddr == relay_pkg::REG_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[relay_pkg::IRQ_W-1:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : relay_board_io_watchdog

// ==== tb/relay_board_io_watchdog_asserts.sv ====
`timescale 1ns/1ns
module relay_board_io_watchdog_asserts #(
  parameter longint unsigned WDOG_CYCLES = relay_pkg::WDOG_CYCLES
) (
  // APB and interrupt
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  // Serial pins and outputs
  input wire logic              scl,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire relay_pkg::drive_t drive,
  input wire relay_pkg::led_t   leds
);
  logic            seen_ack;
  longint unsigned idle_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_ack <= 1'b0;
    else if (sda_oe) seen_ack <= 1'b1;
  end
  // Cycles since the indicator last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt <= 0;
    else if ($changed(leds.watchdog_indicator_led)) idle_cnt <= 0;
    else idle_cnt <= idle_cnt + 1;
  end
  property p_ir_led;
    leds.ir_source_led == drive.ir_source;
  endproperty
  a_ir_led: assert property (p_ir_led) else $error("source LED wrong");
  property p_cal_led;
    leds.sample_cal_valve_led == drive.sample_cal_valve;
  endproperty
  a_cal_led: assert property (p_cal_led) else $error("cal LED wrong");
  property p_span_led;
    leds.zero_span_valve_led == drive.zero_span_valve;
  endproperty
  a_span_led: assert property (p_span_led) else $error("span LED wrong");
  property p_shut_led;
    leds.shutoff_valve_led == drive.shutoff_valve;
  endproperty
  a_shut_led: assert property (p_shut_led) else $error("shutoff LED wrong");
  property p_heat_led;
    {leds.bench_heater_led, leds.wheel_heater_led} == {drive.bench_heater, drive.wheel_heater};
  endproperty
  a_heat_led: assert property (p_heat_led) else $error("heater LED wrong");
  property p_hold;
    !seen_ack |-> drive == relay_pkg::DRIVE_POWERUP && leds == 8'h80;
  endproperty
  a_hold: assert property (p_hold) else $error("power-up values lost");
  property p_ind_bus;
    $changed(leds.watchdog_indicator_led) |-> sda_oe;
  endproperty
  a_ind_bus: assert property (p_ind_bus) else $error("indicator moved without write");
  property p_motor;
    $changed(drive.wheel_motor) |-> sda_oe;
  endproperty
  a_motor: assert property (p_motor) else $error("motor changed without write");
  property p_trip_late;
    $fell(drive.ir_source) && !sda_oe |-> idle_cnt + 2 >= WDOG_CYCLES;
  endproperty
  a_trip_late: assert property (p_trip_late) else $error("shutdown too early");
  c_trip: cover property ($fell(drive.ir_source) && !sda_oe);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule : relay_board_io_watchdog_asserts

bind relay_board_io_watchdog relay_board_io_watchdog_asserts #(.WDOG_CYCLES(WDOG_CYCLES))
  relay_board_io_watchdog_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .drive(drive), .leds(leds));

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/1ns
module i2c_host_model (
  // Reference clock and wire level
  input  wire logic pclk,
  input  wire logic sda_line,
  // Open-drain host pins
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data set in the low phase, sampled late in the high phase
  task automatic bit_cycle(input logic b, output logic seen);
    sda_low = !b;
    #16;
    scl = 1'b1;
    #12;
    seen = sda_line;
    #4;
    scl = 1'b0;
  endtask : bit_cycle
  task automatic send(input logic [6:0] addr, input logic [7:0] b0, input logic [7:0] b1,
                      output logic [2:0] acks);
    logic [23:0] sh;
    logic        s;
    sh = {addr, 1'b0, b0, b1};
    @(posedge pclk);
    #1;
    sda_low = 1'b1;
    #16;
    scl = 1'b0;
    for (int k = 0; k < 24; k++) begin
      bit_cycle(sh[23-k], s);
      if (k % 8 == 7) begin
        bit_cycle(1'b1, s);
        acks[2-k/8] = !s;
      end
    end
    // Stop: data rises while the clock is high, then the clock stands still
    sda_low = 1'b1;
    #16;
    scl = 1'b1;
    #16;
    sda_low = 1'b0;
    #16;
  endtask : send
endmodule : i2c_host_model

// ==== tb/relay_board_io_watchdog_bench.sv ====
`timescale 1ns/1ns
module relay_board_io_watchdog_bench;
  localparam longint unsigned WDC = 1000;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, irq, scl, sda_out, sda_oe, sda_low, sda_line, er, wd;
  logic [2:0]        acks;
  relay_pkg::drive_t drive;
  relay_pkg::led_t   leds;
  int                err_count, total_checks;
  assign sda_line = !(sda_low || (sda_oe && !sda_out));
  relay_board_io_watchdog #(.WDOG_CYCLES(WDC)) relay_board_io_watchdog_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .drive(drive), .leds(leds));
  i2c_host_model i2c_host_model_inst (
    .pclk(pclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [7:0] exp_leds(input logic [6:0] d, input logic [1:0] ind);
    return {d[5], d[2], d[1], d[0], ind[1], d[4], d[3], ind[0]};
  endfunction : exp_leds
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmd(input logic [6:0] d, input logic sp);
    wd = !wd;
    i2c_host_model_inst.send(relay_pkg::I2C_ADDR, {1'b0, d}, {6'h0, sp, wd}, acks);
    chk({29'h0, acks}, 32'h0000_0007);
    repeat (4) @(posedge pclk);
    chk({25'h0, drive}, {25'h0, d});
    chk({24'h0, leds}, {24'h0, exp_leds(d, {sp, wd})});
  endtask : cmd
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    #100_000;
    err_count++;
    conclude();
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    wd = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({24'h0, leds}, 32'h0000_0080);
    apb(relay_pkg::REG_CONFIG, 1'b0, 32'h0000_0000);
    chk(rd, relay_pkg::CONFIG_RST);
    apb(relay_pkg::REG_IRQ_MASK, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(8'h10, 1'b1, 32'h0000_00FF);
    chk({31'h0, er}, 32'h0000_0001);
    apb(8'h10, 1'b0, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(relay_pkg::REG_STATUS, 1'b1, 32'hFFFF_FFFF);
    apb(relay_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_8060);
    i2c_host_model_inst.send(7'h21, 8'h7F, 8'h01, acks);
    chk({29'h0, acks}, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    chk({25'h0, drive}, 32'h0000_0060);
    cmd(7'h7F, 1'b0);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(relay_pkg::REG_IRQ_MASK, 1'b1, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(relay_pkg::REG_IRQ_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(relay_pkg::REG_IRQ_STAT, 1'b1, 32'h0000_0006);
    apb(relay_pkg::REG_IRQ_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    for (int i = 0; i < 6; i++) cmd(7'h40 | (7'h01 << i), i == 2);
    cmd(7'h7F, 1'b0);
    cmd(7'h7F, 1'b0);
    repeat (850) @(posedge pclk);
    chk({25'h0, drive}, 32'h0000_007F);
    apb(relay_pkg::REG_IRQ_STAT, 1'b1, 32'h0000_0007);
    repeat (300) @(posedge pclk);
    chk({25'h0, drive}, 32'h0000_0040);
    chk({24'h0, leds}, {24'h0, exp_leds(7'h40, {1'b0, wd})});
    apb(relay_pkg::REG_IRQ_STAT, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(relay_pkg::REG_STATUS, 1'b0, 32'h0000_0000);
    chk(rd, {14'h0, 2'b11, exp_leds(7'h40, {1'b0, wd}), 1'b0, 7'h40});
    cmd(7'h7F, 1'b0);
    apb(relay_pkg::REG_CONFIG, 1'b1, 32'h0000_0000);
    repeat (1100) @(posedge pclk);
    chk({25'h0, drive}, 32'h0000_007F);
    conclude();
  end
endmodule : relay_board_io_watchdog_bench
